// ### dab_cond_eval.sv
// Branch condition evaluator for the conditional branch family
`timescale 1ns/1ps
module dab_cond_eval (
	input wire logic [1:0] condSelector,
	input wire logic [3:0] maskField,
	input wire logic [3:0] stateField,
	input wire logic branchInputPin,
	input wire logic testFlag,
	input wire logic [3:0] accConditions,
	output logic condMet
);

	// Mask bits pick conditions whose live state equals the asked state
	logic [3:0] hitBits;

	// Selector picks pin, flag or accumulator conditions
	always_comb begin
		hitBits = maskField & ~(accConditions ^ stateField);
		case (condSelector)
			dab_pkg::SEL_PIN_LOW: condMet = ~branchInputPin;
			dab_pkg::SEL_FLAG_SET: condMet = testFlag;
			dab_pkg::SEL_FLAG_CLR: condMet = ~testFlag;
			dab_pkg::SEL_ACC: condMet = |hitBits;
			default: condMet = 1'b0;
		endcase
	end

endmodule : dab_cond_eval

// ### dab_decoder.sv
// Opcode decoder and fetch sequencer with APB control registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module dab_decoder #(
	parameter int ADDR_W = 12,
	parameter int PC_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Program memory fetch
	output logic fetchReq,
	output logic [PC_W-1:0] fetchAddr,
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	// Processor state that the branches test
	input wire logic branchInputPin,
	input wire logic testFlag,
	input wire logic [3:0] accConditions,
	input wire logic auxNonZero,
	input wire logic [PC_W-1:0] accLow,
	// One result per finished instruction
	output logic retireValid,
	output logic [4:0] retireClass,
	output logic [1:0] retireWords,
	output logic [3:0] retireCycles,
	output logic retireTaken,
	output logic [15:0] retireOperand
);

	// All state of the block
	typedef struct packed {
		dab_pkg::dab_state_e state;
		logic [PC_W-1:0] pc;
		logic [15:0] opWord;
		logic [15:0] operand;
		dab_pkg::dab_class_e opClass;
		logic [1:0] words;
		logic [3:0] cycles;
		logic [3:0] cycLeft;
		logic taken;
		logic fetchReq;
		logic [PC_W-1:0] fetchAddr;
		logic retire;
		logic run;
		logic illegal;
		logic [31:0] retired;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dab_regs_s;

	dab_regs_s q; // Registered state
	dab_regs_s d; // Next state

	// Condition result for the word held in opWord
	logic condMet;

	// Condition fields sit in the low byte and selector bits
	dab_cond_eval u_cond (
		.condSelector(q.opWord[dab_pkg::SEL_LSB +: 2]),
		.maskField(q.opWord[dab_pkg::MASK_LSB +: 4]),
		.stateField(q.opWord[dab_pkg::STATE_LSB +: 4]),
		.branchInputPin(branchInputPin),
		.testFlag(testFlag),
		.accConditions(accConditions),
		.condMet(condMet)
	);

	// Bus handshake terms
	logic accessCyc; // First access cycle, answer not yet given
	logic doneCyc; // Edge at which the master sees pready
	logic [11:0] regOff; // Byte offset within the block
	dab_pkg::dab_class_e fetchedClass; // Class of the incoming word

	assign accessCyc = psel & penable & ~q.pready;
	assign doneCyc = psel & penable & q.pready;
	assign regOff = 12'(paddr);
	assign fetchedClass = dab_pkg::dab_classify(instrWord);

	// Next-state logic: bus slave, registers and fetch sequencer
	always_comb begin
		d = q;
		d.retire = 1'b0;
		d.pready = 1'b0;
		d.pslverr = 1'b0;

		// Read answer is latched one cycle into the access phase
		if (accessCyc) begin
			d.pready = 1'b1;
			d.prdata = dab_pkg::WORD_ZERO;
			case (regOff)
				dab_pkg::REG_CTRL: begin
					d.prdata[dab_pkg::CTRL_RUN_BIT] = q.run;
				end
				dab_pkg::REG_START: begin
					d.prdata[PC_W-1:0] = q.pc;
				end
				dab_pkg::REG_STATUS: begin
					// Busy plus sticky illegal flag and live counter
					d.prdata[dab_pkg::STAT_BUSY_BIT] = (q.state != dab_pkg::ST_IDLE);
					d.prdata[dab_pkg::STAT_ILL_BIT] = q.illegal;
					d.prdata[dab_pkg::STAT_PC_LSB +: PC_W] = q.pc;
				end
				dab_pkg::REG_LAST: begin
					d.prdata[4:0] = q.opClass;
					d.prdata[dab_pkg::LAST_WORDS_LSB +: 2] = q.words;
					d.prdata[dab_pkg::LAST_CYC_LSB +: 4] = q.cycles;
					d.prdata[dab_pkg::LAST_TAKEN_BIT] = q.taken;
				end
				dab_pkg::REG_OPERAND: begin
					d.prdata[15:0] = q.operand;
				end
				dab_pkg::REG_RETIRED: begin
					d.prdata = q.retired;
				end
				default: begin
					// Unmapped offsets answer with an error
					d.pslverr = 1'b1;
				end
			endcase
		end

		// Writes act only on the edge where pready is seen
		if (doneCyc && pwrite) begin
			case (regOff)
				dab_pkg::REG_CTRL: begin
					d.run = pwdata[dab_pkg::CTRL_RUN_BIT];
				end
				dab_pkg::REG_START: begin
					// A running sequencer owns the counter
					if (q.state == dab_pkg::ST_IDLE) begin
						d.pc = pwdata[PC_W-1:0];
					end
				end
				dab_pkg::REG_STATUS: begin
					// Write one to clear; a new set below wins
					if (pwdata[dab_pkg::STAT_ILL_BIT]) begin
						d.illegal = 1'b0;
					end
				end
				dab_pkg::REG_RETIRED: begin
					d.retired = pwdata;
				end
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end

		// Fetch and decode sequencer
		case (q.state)
			dab_pkg::ST_IDLE: begin
				// Start fetching once software enables the run bit
				if (q.run) begin
					d.fetchReq = 1'b1;
					d.fetchAddr = q.pc;
					d.state = dab_pkg::ST_FETCH;
				end
			end

			dab_pkg::ST_FETCH: begin
				// Opcode word arrives; class decides the word count
				if (instrValid) begin
					d.opWord = instrWord;
					d.opClass = fetchedClass;
					d.operand = 16'h0000;
					case (fetchedClass)
						dab_pkg::CL_ADD_LONG,
						dab_pkg::CL_AND_LONG,
						dab_pkg::CL_AND_LONG16,
						dab_pkg::CL_BRANCH,
						dab_pkg::CL_LOOP,
						dab_pkg::CL_COND: begin
							// Second word follows the opcode
							d.words = dab_pkg::WORDS_TWO;
							d.fetchAddr = PC_W'(q.pc + dab_pkg::PC_STEP_ONE);
							d.state = dab_pkg::ST_OPER;
						end
						default: begin
							d.words = dab_pkg::WORDS_ONE;
							d.fetchReq = 1'b0;
							d.state = dab_pkg::ST_RESOLVE;
						end
					endcase
				end
			end

			dab_pkg::ST_OPER: begin
				// Constant or branch target word
				if (instrValid) begin
					d.operand = instrWord;
					d.fetchReq = 1'b0;
					d.state = dab_pkg::ST_RESOLVE;
				end
			end

			dab_pkg::ST_RESOLVE: begin
				// Default: fall through, straight-line timing
				d.taken = 1'b0;
				d.pc = q.pc + PC_W'(q.words);
				d.cycles = dab_pkg::CYC_ONE;
				case (q.opClass)
					dab_pkg::CL_ADD_LONG,
					dab_pkg::CL_AND_LONG,
					dab_pkg::CL_AND_LONG16: begin
						d.cycles = dab_pkg::CYC_TWO;
					end
					dab_pkg::CL_BRANCH: begin
						// Unconditional jump to the second word
						d.taken = 1'b1;
						d.pc = PC_W'(q.operand);
						d.cycles = dab_pkg::CYC_JUMP;
					end
					dab_pkg::CL_COMPUTED: begin
						// Target comes from the accumulator
						d.taken = 1'b1;
						d.pc = accLow;
						d.cycles = dab_pkg::CYC_JUMP;
					end
					dab_pkg::CL_LOOP: begin
						// Taken while the auxiliary register is nonzero
						d.taken = auxNonZero;
						d.pc = auxNonZero ? PC_W'(q.operand) : PC_W'(q.pc + dab_pkg::PC_STEP_TWO);
						d.cycles = auxNonZero ? dab_pkg::CYC_JUMP : dab_pkg::CYC_SKIP;
					end
					dab_pkg::CL_COND: begin
						// Pin form skips in three cycles, others in two
						d.taken = condMet;
						d.pc = condMet ? PC_W'(q.operand) : PC_W'(q.pc + dab_pkg::PC_STEP_TWO);
						if (condMet) begin
							d.cycles = dab_pkg::CYC_JUMP;
						end else if (q.opWord[dab_pkg::SEL_LSB +: 2] == dab_pkg::SEL_PIN_LOW) begin
							d.cycles = dab_pkg::CYC_SKIP_PIN;
						end else begin
							d.cycles = dab_pkg::CYC_SKIP;
						end
					end
					dab_pkg::CL_UNKNOWN: begin
						// Treated as a one-cycle no-op and flagged
						d.illegal = 1'b1;
					end
					default: begin
						// One-word, one-cycle forms
						d.cycles = dab_pkg::CYC_ONE;
					end
				endcase
				d.cycLeft = d.cycles - dab_pkg::CYC_ONE;
				d.state = dab_pkg::ST_EXEC;
			end

			dab_pkg::ST_EXEC: begin
				// Hold for the cycle figure, then report
				if (q.cycLeft == 4'h0) begin
					d.retire = 1'b1;
					d.retired = q.retired + 32'h0000_0001;
					// Stop cleanly at an instruction boundary
					if (q.run) begin
						d.fetchReq = 1'b1;
						d.fetchAddr = q.pc;
						d.state = dab_pkg::ST_FETCH;
					end else begin
						d.state = dab_pkg::ST_IDLE;
					end
				end else begin
					d.cycLeft = q.cycLeft - 4'h1;
				end
			end

			default: begin
				// Lost one-hot code: recover to idle
				d.fetchReq = 1'b0;
				d.state = dab_pkg::ST_IDLE;
			end
		endcase
	end

	// State register, synchronous reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.state <= dab_pkg::ST_IDLE;
			q.pc <= dab_pkg::PC_RESET;
			q.fetchAddr <= dab_pkg::PC_RESET;
			q.opClass <= dab_pkg::CL_UNKNOWN;
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign fetchReq = q.fetchReq;
	assign fetchAddr = q.fetchAddr;
	assign retireValid = q.retire;
	assign retireClass = q.opClass;
	assign retireWords = q.words;
	assign retireCycles = q.cycles;
	assign retireTaken = q.taken;
	assign retireOperand = q.operand;

endmodule : dab_decoder

// ### dab_decoder_sva.sv
// Checker for fetch handshake and retire results of the decoder
`timescale 1ns/1ps
module dab_decoder_sva #(
	parameter int PC_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic fetchReq,
	input wire logic [PC_W-1:0] fetchAddr,
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	input wire logic branchInputPin,
	input wire logic testFlag,
	input wire logic [3:0] accConditions,
	input wire logic auxNonZero,
	input wire logic retireValid,
	input wire logic [1:0] retireWords,
	input wire logic [3:0] retireCycles,
	input wire logic retireTaken,
	input wire logic [15:0] retireOperand
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic first; // Word taken now is an opcode
	logic needOp_q; // Waiting for an opcode
	logic took_q; // A word was taken at the last edge
	logic [15:0] op_q; // Opcode in flight
	logic [15:0] opnd_q; // Its second word
	logic [7:0] cond_q; // Inputs seen in the resolve cycle
	logic met; // Accumulator test by mask and wanted state
	assign first = needOp_q || retireValid;
	assign met = |(op_q[3:0] & ~(cond_q[3:0] ^ op_q[7:4]));
	// Next opcode may be taken at the very edge of a retire
	always_ff @(posedge core_clk) begin
		needOp_q <= !rst_n || (first && !(fetchReq && instrValid));
		took_q <= rst_n && fetchReq && instrValid;
		if (fetchReq && instrValid && first) begin
			op_q <= instrWord;
		end
		if (fetchReq && instrValid && !first) begin
			opnd_q <= instrWord;
		end
		// Resolve cycle follows the last take, so the final sample wins
		if (took_q) begin
			cond_q <= {branchInputPin, testFlag, auxNonZero, 1'b0, accConditions};
		end
	end
	a_pin_low: assert property (retireValid && op_q[15:8] == 8'hE0
		|-> retireTaken == !cond_q[7])
	else $error("pin branch decision wrong");
	a_flag_test: assert property (retireValid && (op_q[15:8] == 8'hE1 || op_q[15:8] == 8'hE2)
		|-> retireTaken == (cond_q[6] ^ op_q[9]))
	else $error("flag branch decision wrong");
	a_acc_test: assert property (retireValid && op_q[15:8] == 8'hE3
		|-> retireTaken == met)
	else $error("accumulator branch decision wrong");
	a_cond_cycles: assert property (retireValid && op_q[15:10] == 6'h38
		|-> retireWords == 2'h2 && retireCycles == (retireTaken ? 4'h4 : (op_q[9:8] == 2'h0 ? 4'h3 : 4'h2)))
	else $error("conditional branch cycles wrong");
	a_loop_branch: assert property (retireValid && op_q[15:8] == 8'h7B |-> retireTaken == cond_q[5]
		&& retireCycles == (cond_q[5] ? 4'h4 : 4'h2))
	else $error("loop branch result wrong");
	a_two_operand: assert property (retireValid && retireWords == 2'h2 |-> retireOperand == opnd_q)
	else $error("second word not used");
	a_long_forms: assert property (retireValid && (op_q[15:4] == 12'hBF9 || op_q[15:6] == 10'h2FE
		|| op_q[15:6] == 10'h2FA) |-> retireWords == 2'h2 && retireCycles == 4'h2)
	else $error("long immediate form size wrong");
	a_single_ops: assert property (
		retireValid && (op_q == 16'hBE00 || op_q == 16'hBE04 || op_q[15:12] == 4'h2 || op_q[15:10] == 6'h18
		|| op_q[15:8] == 8'h78 || op_q[15:8] == 8'h6E || op_q[15:8] == 8'hB8)
		|-> retireWords == 2'h1 && retireCycles == 4'h1 && !retireTaken)
	else $error("one-word operation size wrong");
	a_computed_jump: assert property (retireValid && op_q == 16'hBE20
		|-> retireTaken && retireWords == 2'h1 && retireCycles == 4'h4)
	else $error("computed jump result wrong");
	a_fetch_hold: assert property (fetchReq && !instrValid |=> fetchReq && $stable(fetchAddr))
	else $error("fetch request dropped early");
endmodule : dab_decoder_sva
bind dab_decoder dab_decoder_sva #(.PC_W(PC_W)) i_sva (.core_clk, .rst_n, .fetchReq, .fetchAddr, .instrWord,
	.instrValid, .branchInputPin, .testFlag, .accConditions, .auxNonZero, .retireValid, .retireWords,
	.retireCycles, .retireTaken, .retireOperand);

// ### dab_pkg.sv
// Package: constants, types and opcode table of the instruction decoder
package dab_pkg;

	// APB register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_START = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_LAST = 12'h00C;
	localparam logic [11:0] REG_OPERAND = 12'h010;
	localparam logic [11:0] REG_RETIRED = 12'h014;

	// Values after reset
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Register bit positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ILL_BIT = 1;
	localparam int STAT_PC_LSB = 16;
	localparam int LAST_WORDS_LSB = 8;
	localparam int LAST_CYC_LSB = 16;
	localparam int LAST_TAKEN_BIT = 24;

	// Instruction field positions
	localparam int MASK_LSB = 0;
	localparam int STATE_LSB = 4;
	localparam int SEL_LSB = 8;

	// Cycle figures
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_TWO = 4'h2;
	localparam logic [3:0] CYC_JUMP = 4'h4;
	localparam logic [3:0] CYC_SKIP = 4'h2;
	localparam logic [3:0] CYC_SKIP_PIN = 4'h3;

	// Program counter steps
	localparam logic [15:0] PC_STEP_ONE = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO = 16'h0002;
	localparam logic [1:0] WORDS_ONE = 2'h1;
	localparam logic [1:0] WORDS_TWO = 2'h2;

	// Condition selector codes
	localparam logic [1:0] SEL_PIN_LOW = 2'h0;
	localparam logic [1:0] SEL_FLAG_SET = 2'h1;
	localparam logic [1:0] SEL_FLAG_CLR = 2'h2;
	localparam logic [1:0] SEL_ACC = 2'h3;

	// Opcode patterns, ? marks operand bits
	localparam logic [15:0] PAT_ABS = 16'hBE00;
	localparam logic [15:0] PAT_PRODUCT = 16'hBE04;
	localparam logic [15:0] PAT_COMPUTED = 16'hBE20;
	localparam logic [15:0] PAT_ADD_LONG = 16'hBF9?;
	localparam logic [15:0] PAT_AND_LONG = 16'b1011_1111_10??_????;
	localparam logic [15:0] PAT_AND_LONG16 = 16'b1011_1110_10??_????;
	localparam logic [15:0] PAT_ADD_SHIFT = 16'h2???;
	localparam logic [15:0] PAT_ADD_CARRY = 16'h60??;
	localparam logic [15:0] PAT_ADD_HIGH = 16'h61??;
	localparam logic [15:0] PAT_ADD_UNSIGNED = 16'h62??;
	localparam logic [15:0] PAT_ADD_VARSHIFT = 16'h63??;
	localparam logic [15:0] PAT_AND_DATA = 16'h6E??;
	localparam logic [15:0] PAT_AUX_INC = 16'h78??;
	localparam logic [15:0] PAT_BRANCH = 16'h79??;
	localparam logic [15:0] PAT_LOOP = 16'h7B??;
	localparam logic [15:0] PAT_ADD_SHORT = 16'hB8??;
	localparam logic [15:0] PAT_COND = 16'b1110_00??_????_????;

	// Instruction classes
	typedef enum logic [4:0] {
		CL_UNKNOWN, CL_ABS, CL_ADD_SHIFT, CL_ADD_HIGH, CL_ADD_SHORT,
		CL_ADD_LONG, CL_ADD_CARRY, CL_ADD_UNSIGNED, CL_ADD_VARSHIFT,
		CL_AUX_INC, CL_AND_DATA, CL_AND_LONG, CL_AND_LONG16, CL_PRODUCT,
		CL_BRANCH, CL_COMPUTED, CL_LOOP, CL_COND
	} dab_class_e;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_FETCH = 5'h02,
		ST_OPER = 5'h04,
		ST_RESOLVE = 5'h08,
		ST_EXEC = 5'h10
	} dab_state_e;

	// Opcode to class; exact codes are checked before wider patterns
	function automatic dab_class_e dab_classify(input logic [15:0] w);
		dab_class_e c;
		c = CL_UNKNOWN;
		casez (w)
			PAT_ABS: c = CL_ABS;
			PAT_PRODUCT: c = CL_PRODUCT;
			PAT_COMPUTED: c = CL_COMPUTED;
			PAT_ADD_LONG: c = CL_ADD_LONG;
			PAT_AND_LONG: c = CL_AND_LONG;
			PAT_AND_LONG16: c = CL_AND_LONG16;
			PAT_ADD_SHIFT: c = CL_ADD_SHIFT;
			PAT_ADD_CARRY: c = CL_ADD_CARRY;
			PAT_ADD_HIGH: c = CL_ADD_HIGH;
			PAT_ADD_UNSIGNED: c = CL_ADD_UNSIGNED;
			PAT_ADD_VARSHIFT: c = CL_ADD_VARSHIFT;
			PAT_AND_DATA: c = CL_AND_DATA;
			PAT_AUX_INC: c = CL_AUX_INC;
			PAT_BRANCH: c = CL_BRANCH;
			PAT_LOOP: c = CL_LOOP;
			PAT_ADD_SHORT: c = CL_ADD_SHORT;
			PAT_COND: c = CL_COND;
			default: c = CL_UNKNOWN;
		endcase
		return c;
	endfunction : dab_classify

endpackage : dab_pkg

// ### dab_prog_mem.sv
// Program memory model answering instruction fetches after a chosen lag
`timescale 1ns/1ps
module dab_prog_mem (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic fetchReq,
	input wire logic [15:0] fetchAddr,
	input wire logic [1:0] lagCycles,
	output logic [15:0] instrWord,
	output logic instrValid
);
	// Model state: cycles waited and last word handed over
	typedef struct packed {
		logic [1:0] waitCnt;
		logic [15:0] lastWord;
	} dab_mem_s;
	logic [15:0] mem [0:65535]; // Program words, loaded by the bench
	dab_mem_s state_q;
	dab_mem_s state_d;
	// Unused words read as unknown opcodes
	initial begin
		for (int a = 0; a < 65536; a++) begin
			mem[a] = 16'hFFFF;
		end
	end
	// Answer once the request has waited lagCycles; each fetch gets its own word
	always_comb begin
		state_d = state_q;
		instrValid = fetchReq && (state_q.waitCnt >= lagCycles);
		// Idle bus shows the inverse of the last word, so a stale read never matches
		instrWord = instrValid ? mem[fetchAddr] : ~state_q.lastWord;
		if (instrValid) begin
			state_d.waitCnt = 2'h0;
			state_d.lastWord = mem[fetchAddr];
		end else if (fetchReq) begin
			state_d.waitCnt = state_q.waitCnt + 2'h1;
		end
	end
	// Register the model state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end
endmodule : dab_prog_mem

// ### dsp_arith_branch_opcode_decode_tb.sv
// Bench: a chained program runs through the decoder, each retire is checked
`timescale 1ns/1ps
module dsp_arith_branch_opcode_decode_tb;
	// One row: opcode, pin/flag/aux/accumulator inputs, class, words-cycles-taken
	typedef struct {
		logic [15:0] op;
		logic [7:0] cnd;
		dab_pkg::dab_class_e cls;
		logic [11:0] exp;
	} dab_row_s;
	localparam int NROW = 29;
	dab_row_s rows [NROW] = '{
		'{16'hBE00, 8'h00, dab_pkg::CL_ABS, 12'h110},
		'{16'h2A85, 8'h00, dab_pkg::CL_ADD_SHIFT, 12'h110},
		'{16'h6105, 8'h00, dab_pkg::CL_ADD_HIGH, 12'h110},
		'{16'hB87F, 8'h00, dab_pkg::CL_ADD_SHORT, 12'h110},
		'{16'hBF93, 8'h00, dab_pkg::CL_ADD_LONG, 12'h220},
		'{16'h6003, 8'h00, dab_pkg::CL_ADD_CARRY, 12'h110},
		'{16'h62FF, 8'h00, dab_pkg::CL_ADD_UNSIGNED, 12'h110},
		'{16'h6301, 8'h00, dab_pkg::CL_ADD_VARSHIFT, 12'h110},
		'{16'h78FF, 8'h00, dab_pkg::CL_AUX_INC, 12'h110},
		'{16'h6E10, 8'h00, dab_pkg::CL_AND_DATA, 12'h110},
		'{16'hBF85, 8'h00, dab_pkg::CL_AND_LONG, 12'h220},
		'{16'hBEBF, 8'h00, dab_pkg::CL_AND_LONG16, 12'h220},
		'{16'hBE04, 8'h00, dab_pkg::CL_PRODUCT, 12'h110},
		'{16'hBE20, 8'h00, dab_pkg::CL_COMPUTED, 12'h141},
		'{16'h7980, 8'h00, dab_pkg::CL_BRANCH, 12'h241},
		'{16'h7B80, 8'h20, dab_pkg::CL_LOOP, 12'h241},
		'{16'h7B80, 8'h00, dab_pkg::CL_LOOP, 12'h220},
		'{16'hE000, 8'h00, dab_pkg::CL_COND, 12'h241},
		'{16'hE000, 8'h80, dab_pkg::CL_COND, 12'h230},
		'{16'hE100, 8'h40, dab_pkg::CL_COND, 12'h241},
		'{16'hE100, 8'h00, dab_pkg::CL_COND, 12'h220},
		'{16'hE200, 8'h00, dab_pkg::CL_COND, 12'h241},
		'{16'hE200, 8'h40, dab_pkg::CL_COND, 12'h220},
		'{16'hE38C, 8'h00, dab_pkg::CL_COND, 12'h241},
		'{16'hE38C, 8'h04, dab_pkg::CL_COND, 12'h220},
		'{16'hE3F0, 8'h0F, dab_pkg::CL_COND, 12'h220},
		'{16'hE322, 8'h02, dab_pkg::CL_COND, 12'h241},
		'{16'hE311, 8'h40, dab_pkg::CL_COND, 12'h220},
		'{16'hFFFF, 8'h00, dab_pkg::CL_UNKNOWN, 12'h110}
	};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fetchReq;
	logic [15:0] fetchAddr;
	logic [15:0] instrWord;
	logic instrValid;
	logic branchInputPin = 1'b1;
	logic testFlag = 1'b0;
	logic [3:0] accConditions = 4'h0;
	logic auxNonZero = 1'b0;
	logic [15:0] accLow = 16'h0000;
	logic [1:0] lagCycles = 2'h0;
	logic retireValid;
	logic [4:0] retireClass;
	logic [1:0] retireWords;
	logic [3:0] retireCycles;
	logic retireTaken;
	logic [15:0] retireOperand;
	logic [15:0] adr [NROW + 1]; // Address of each row's opcode
	logic [31:0] rd; // Last APB read data
	logic err; // Last APB error flag
	int nFail = 0;
	int samplesChecked = 0;
	int nRetired = 0; // Retires seen since reset
	dab_decoder i_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.fetchReq, .fetchAddr, .instrWord, .instrValid, .branchInputPin, .testFlag, .accConditions, .auxNonZero,
		.accLow, .retireValid, .retireClass, .retireWords, .retireCycles, .retireTaken, .retireOperand);
	dab_prog_mem i_mem (.core_clk, .rst_n, .fetchReq, .fetchAddr, .instrWord, .instrValid, .lagCycles);
	// 200 MHz clock
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	// Count retire pulses for the retire counter check
	always @(posedge core_clk) begin
		nRetired <= !rst_n ? 0 : nRetired + int'(retireValid === 1'b1);
	end
	// Report, verdict and end of run
	task automatic testDone;
		$display("Comparisons %0d, mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : testDone
	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samplesChecked++;
		if (seen !== want) begin
			nFail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	// One APB transfer; waits for pready with a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			nFail++;
			testDone();
		end
	endtask : apb
	// Drive the processor state that row i is resolved against
	task automatic setRow(input int i);
		branchInputPin <= rows[i].cnd[7];
		testFlag <= rows[i].cnd[6];
		auxNonZero <= rows[i].cnd[5];
		accConditions <= rows[i].cnd[3:0];
		accLow <= adr[i] + 16'h0010;
		lagCycles <= 2'(i);
	endtask : setRow
	// Main sequence: reset, chained program, then register and reset cases
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		// Each taken branch lands 16 words on, others fall through
		adr[0] = 16'h0040;
		for (int i = 0; i < NROW; i++) begin
			i_mem.mem[adr[i]] = rows[i].op;
			i_mem.mem[adr[i] + 16'h0001] = adr[i] + 16'h0010;
			adr[i + 1] = adr[i] + (rows[i].exp[0] ? 16'h0010 : 16'(rows[i].exp[11:8]));
		end
		setRow(0);
		apb(1'b1, dab_pkg::REG_START, {16'h0000, adr[0]});
		apb(1'b1, dab_pkg::REG_CTRL, 32'h0000_0001);
		for (int i = 0; i < NROW; i++) begin
			for (int k = 0; k < 100 && retireValid !== 1'b1; k++) begin
				@(posedge core_clk);
			end
			// A row that never retires is a hang: count it and close the run
			if (retireValid !== 1'b1) begin
				nFail++;
				testDone();
			end
			chk(32'(retireClass), 32'(rows[i].cls));
			chk(32'({retireWords, retireCycles, 3'h0, retireTaken}), 32'(rows[i].exp));
			if (rows[i].exp[11:8] == 4'h2) begin
				chk(32'(retireOperand), 32'(adr[i] + 16'h0010));
			end
			chk(32'(fetchAddr), 32'(adr[i + 1]));
			if (i + 1 < NROW) begin
				setRow(i + 1);
			end
			@(posedge core_clk);
		end
		// Stop, then sticky illegal flag, retire count and an unmapped offset
		apb(1'b1, dab_pkg::REG_CTRL, 32'h0000_0000);
		for (int k = 0; k < 20 && !(rd[0] === 1'b0 && k > 0); k++) begin
			apb(1'b0, dab_pkg::REG_STATUS, 32'h0000_0000);
		end
		// Sequencer that never goes idle is a hang
		if (rd[0] !== 1'b0) begin
			nFail++;
			testDone();
		end
		chk(32'(rd[1:0]), 32'h0000_0002);
		apb(1'b1, dab_pkg::REG_STATUS, 32'h0000_0002);
		apb(1'b0, dab_pkg::REG_STATUS, 32'h0000_0000);
		chk(32'(rd[1:0]), 32'h0000_0000);
		// Trailing filler words are unknown forms: class 0, one word, one cycle
		apb(1'b0, dab_pkg::REG_LAST, 32'h0000_0000);
		chk(rd, 32'h0001_0100);
		apb(1'b0, dab_pkg::REG_OPERAND, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, dab_pkg::REG_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		// Start address is writable while idle
		apb(1'b1, dab_pkg::REG_START, 32'h0000_1234);
		apb(1'b0, dab_pkg::REG_START, 32'h0000_0000);
		chk(rd, 32'h0000_1234);
		apb(1'b0, dab_pkg::REG_RETIRED, 32'h0000_0000);
		chk(rd, 32'(nRetired));
		apb(1'b1, dab_pkg::REG_RETIRED, 32'h0000_00A5);
		apb(1'b0, dab_pkg::REG_RETIRED, 32'h0000_0000);
		chk(rd, 32'h0000_00A5);
		apb(1'b0, 12'h018, 32'h0000_0000);
		chk({rd[30:0], err}, 32'h0000_0001);
		// Second reset clears status and count
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, dab_pkg::REG_STATUS, 32'h0000_0000);
		chk(rd, dab_pkg::WORD_ZERO);
		apb(1'b0, dab_pkg::REG_RETIRED, 32'h0000_0000);
		chk(rd, dab_pkg::WORD_ZERO);
		testDone();
	end
endmodule : dsp_arith_branch_opcode_decode_tb
